// file: design/rcc_pkg.sv
/*
 * Types for the radio calibration and configuration bank.
 * Assumes: included constants come from rcc_regs.svh.
 */
package rcc_pkg;
	typedef enum logic [2:0] {
		RCC_IDLE, RCC_ON_CAL, RCC_ON, RCC_VCO_CAL, RCC_SETTLE, RCC_TX,
		RCC_RX
	} rcc_state_t;
	typedef enum logic [1:0] {
		RCC_FSK2, RCC_MSK, RCC_GFSK, RCC_GMSK
	} rcc_mod_t;
	typedef struct packed {
		rcc_mod_t    modFormat;
		logic        gaussian;
		logic [3:0]  btX10;
		logic [1:0]  ifBandwidthSelect;
		logic        if300k;
		logic [11:0] deviationValue;
		logic [11:0] dataRate;
	} rcc_modem_t;
	typedef struct packed {
		logic       singleEn;
		logic       diffEn;
		logic [5:0] level;
	} rcc_pa_t;
	typedef struct packed {
		logic [7:0] band;
		logic [7:0] ampl;
		logic       calRun;
		logic       useOverride;
	} rcc_vco_t;
endpackage

// file: design/rcc_radio_calib_config.sv
/*
 * APB register bank and radio sequencer: oscillator calibration or its
 * bypass, synthesizer settling, IF filter calibration, amplifier ramp.
 * Assumes: APB master per the protocol, 250 MHz core clock, analog
 * calibration measurements presented on vcoBandMeas/vcoAmplMeas.
 */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rcc_regs.svh"
module rcc_radio_calib_config #(
	parameter int VCO_CAL_CYCLES = `RCC_VCO_CAL_US * `RCC_CLK_MHZ,
	parameter int SETTLE_CYCLES  = `RCC_SETTLE_US * `RCC_CLK_MHZ,
	parameter int IFCAL_CYCLES   = `RCC_IFCAL_US * `RCC_CLK_MHZ
) (
	input  wire logic               core_clk,
	input  wire logic               nrst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [7:0]         vcoBandMeas,
	input  wire logic [7:0]         vcoAmplMeas,
	output rcc_pkg::rcc_modem_t     modemCfg,
	output rcc_pkg::rcc_pa_t        paCtl,
	output rcc_pkg::rcc_vco_t       vcoCtl,
	output logic signed [3:0]       xtalPullSteps,
	output logic                    ifCalRun,
	output rcc_pkg::rcc_state_t     radioState
);
	import rcc_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]  rateLo_reg, rateDev_reg, devLo_reg, ampCfg_reg;
	logic [7:0]  modCfg_reg, imgPhase_reg, imgAmpl_reg, options_reg;
	logic [7:0]  synthCtrl_reg, bandOvr_reg, amplOvr_reg, ovrEn_reg;
	logic [7:0]  vcoSetup_reg, oscSetup_reg, bandRes_reg, amplRes_reg;
	logic [5:0]  fine_reg;
	logic        synthArm_reg;
	logic        vcoDone_reg, ifDone_reg;
	rcc_state_t  state_reg;
	logic [15:0] cnt_reg;
	logic [21:0] acc_reg;
	logic [5:0]  level_reg;
	logic [9:0]  idx;
	logic        wrEn, setup, mapped, readOnly, bypass, bitTick;
	logic        cmdOn, cmdTx, cmdRx, cmdOff, cmdTrx, wantTx_reg;
	logic [22:0] accSum;
	logic [7:0]  rampStep;
	logic [7:0]  levelUp;
	logic [5:0]  target;

	assign idx   = paddr[11:2];
	assign setup = psel && !penable;
	assign wrEn  = psel && penable && pwrite && mapped && !readOnly;

	// ----------------------------------------
	// APB decode and answer
	// ----------------------------------------
	// Known indices; result registers and status are read-only
	always_comb begin
		mapped   = 1'b1;
		readOnly = 1'b0;
		unique case (idx)
			`RCC_IDX_RATE_LO, `RCC_IDX_RATE_DEV, `RCC_IDX_DEV_LO,
			`RCC_IDX_AMP_CFG, `RCC_IDX_MOD_CFG, `RCC_IDX_IMG_PHASE,
			`RCC_IDX_IMG_AMPL, `RCC_IDX_OPTIONS, `RCC_IDX_FINE_PWR,
			`RCC_IDX_SYNTH_CTRL, `RCC_IDX_BAND_OVR, `RCC_IDX_AMPL_OVR,
			`RCC_IDX_OVR_EN, `RCC_IDX_VCO_SETUP, `RCC_IDX_OSC_SETUP,
			`RCC_IDX_COMMAND: mapped = 1'b1;
			`RCC_IDX_CAL_STATUS, `RCC_IDX_BAND_RES,
			`RCC_IDX_AMPL_RES: readOnly = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Zero wait states; error on unmapped or read-only write
	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && readOnly));

	// Read data captured in the setup cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= 32'h0000_0000;
			unique case (idx)
				`RCC_IDX_RATE_LO:    prdata[7:0] <= rateLo_reg;
				`RCC_IDX_RATE_DEV:   prdata[7:0] <= rateDev_reg;
				`RCC_IDX_DEV_LO:     prdata[7:0] <= devLo_reg;
				`RCC_IDX_AMP_CFG:    prdata[7:0] <= ampCfg_reg;
				`RCC_IDX_MOD_CFG:    prdata[7:0] <= modCfg_reg;
				`RCC_IDX_IMG_PHASE:  prdata[7:0] <= imgPhase_reg;
				`RCC_IDX_IMG_AMPL:   prdata[7:0] <= imgAmpl_reg;
				`RCC_IDX_OPTIONS:    prdata[7:0] <= options_reg;
				`RCC_IDX_FINE_PWR:   prdata[5:0] <= fine_reg;
				`RCC_IDX_SYNTH_CTRL: prdata[7:0] <= synthCtrl_reg;
				`RCC_IDX_CAL_STATUS: prdata[7:0] <= {1'b0, state_reg,
					2'b00, ifDone_reg, vcoDone_reg};
				`RCC_IDX_BAND_OVR:   prdata[7:0] <= bandOvr_reg;
				`RCC_IDX_AMPL_OVR:   prdata[7:0] <= amplOvr_reg;
				`RCC_IDX_OVR_EN:     prdata[7:0] <= ovrEn_reg;
				`RCC_IDX_VCO_SETUP:  prdata[7:0] <= vcoSetup_reg;
				`RCC_IDX_OSC_SETUP:  prdata[7:0] <= oscSetup_reg;
				`RCC_IDX_BAND_RES:   prdata[7:0] <= bandRes_reg;
				`RCC_IDX_AMPL_RES:   prdata[7:0] <= amplRes_reg;
				default:             prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Plain read/write storage
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rateLo_reg    <= 8'h00;
			rateDev_reg   <= 8'h00;
			devLo_reg     <= 8'h00;
			ampCfg_reg    <= 8'h00;
			modCfg_reg    <= 8'h00;
			imgPhase_reg  <= 8'h00;
			imgAmpl_reg   <= 8'h00;
			options_reg   <= 8'h00;
			synthCtrl_reg <= 8'h00;
			bandOvr_reg   <= 8'h00;
			amplOvr_reg   <= 8'h00;
			ovrEn_reg     <= 8'h00;
			vcoSetup_reg  <= 8'h00;
			oscSetup_reg  <= 8'h00;
		end else if (wrEn) begin
			unique case (idx)
				`RCC_IDX_RATE_LO:    rateLo_reg <= pwdata[7:0];
				`RCC_IDX_RATE_DEV:   rateDev_reg <= pwdata[7:0];
				`RCC_IDX_DEV_LO:     devLo_reg <= pwdata[7:0];
				`RCC_IDX_AMP_CFG:    ampCfg_reg <= pwdata[7:0];
				`RCC_IDX_MOD_CFG:    modCfg_reg <= pwdata[7:0];
				`RCC_IDX_IMG_PHASE:  imgPhase_reg <= pwdata[7:0];
				`RCC_IDX_IMG_AMPL:   imgAmpl_reg <= pwdata[7:0];
				`RCC_IDX_OPTIONS:    options_reg <= pwdata[7:0];
				`RCC_IDX_SYNTH_CTRL: synthCtrl_reg <= pwdata[7:0];
				`RCC_IDX_BAND_OVR:   bandOvr_reg <= pwdata[7:0];
				`RCC_IDX_AMPL_OVR:   amplOvr_reg <= pwdata[7:0];
				`RCC_IDX_OVR_EN:     ovrEn_reg <= pwdata[7:0];
				`RCC_IDX_VCO_SETUP:  vcoSetup_reg <= pwdata[7:0];
				`RCC_IDX_OSC_SETUP:  oscSetup_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Fine level: direct write, or derived from a coarse write
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fine_reg <= 6'h00;
		end else if (wrEn && idx == `RCC_IDX_FINE_PWR) begin
			fine_reg <= pwdata[`RCC_FINE_F];
		end else if (wrEn && idx == `RCC_IDX_AMP_CFG) begin
			fine_reg <= (6'(pwdata[`RCC_COARSE_F]) << `RCC_FINE_SHIFT)
				+ `RCC_FINE_OFS;
		end
	end

	// Bypass arms only on a 0-to-1 write of the calibration enable
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			synthArm_reg <= 1'b0;
		end else if (wrEn && idx == `RCC_IDX_SYNTH_CTRL) begin
			synthArm_reg <= pwdata[`RCC_SYNTH_CAL_BIT] &&
				!synthCtrl_reg[`RCC_SYNTH_CAL_BIT];
			if (pwdata[`RCC_SYNTH_CAL_BIT] && synthArm_reg)
				synthArm_reg <= 1'b1;
		end
	end

	assign bypass = synthArm_reg && ovrEn_reg == `RCC_OVR_ALL &&
		vcoSetup_reg == `RCC_VCO_BYPASS;

	// ----------------------------------------
	// Commands and sequencer
	// ----------------------------------------
	assign cmdOn  = wrEn && idx == `RCC_IDX_COMMAND &&
		pwdata[7:0] == `RCC_CMD_ON;
	assign cmdTx  = wrEn && idx == `RCC_IDX_COMMAND &&
		pwdata[7:0] == `RCC_CMD_TX;
	assign cmdRx  = wrEn && idx == `RCC_IDX_COMMAND &&
		pwdata[7:0] == `RCC_CMD_RX;
	assign cmdOff = wrEn && idx == `RCC_IDX_COMMAND &&
		pwdata[7:0] == `RCC_CMD_OFF;
	assign cmdTrx = cmdTx || cmdRx;

	// Radio state, phase counter and requested direction
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= RCC_IDLE;
			cnt_reg    <= 16'h0000;
			wantTx_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			if (cmdTrx)
				wantTx_reg <= cmdTx;
			unique case (state_reg)
				RCC_IDLE: begin
					if (cmdOn) begin
						cnt_reg <= 16'h0000;
						state_reg <= options_reg[`RCC_BBCAL_BIT] ?
							RCC_ON_CAL : RCC_ON;
					end
				end
				RCC_ON_CAL: begin
					if (cmdOff)
						state_reg <= RCC_IDLE;
					else if (cnt_reg == 16'(IFCAL_CYCLES - 1))
						state_reg <= RCC_ON;
				end
				RCC_ON, RCC_TX, RCC_RX: begin
					if (cmdOff) begin
						state_reg <= RCC_IDLE;
					end else if (cmdOn) begin
						state_reg <= RCC_ON;
					end else if (cmdTrx) begin
						cnt_reg <= 16'h0000;
						state_reg <= bypass ? RCC_SETTLE
							: RCC_VCO_CAL;
					end
				end
				RCC_VCO_CAL: begin
					if (cmdOff) begin
						state_reg <= RCC_IDLE;
					end else if (cnt_reg == 16'(VCO_CAL_CYCLES - 1)) begin
						cnt_reg <= 16'h0000;
						state_reg <= RCC_SETTLE;
					end
				end
				RCC_SETTLE: begin
					if (cmdOff)
						state_reg <= RCC_IDLE;
					else if (cnt_reg == 16'(SETTLE_CYCLES - 1))
						state_reg <= wantTx_reg ? RCC_TX : RCC_RX;
				end
			endcase
		end
	end

	// Calibration results and completion flags
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bandRes_reg <= 8'h00;
			amplRes_reg <= 8'h00;
			vcoDone_reg <= 1'b0;
			ifDone_reg  <= 1'b0;
		end else begin
			if (state_reg == RCC_VCO_CAL &&
					cnt_reg == 16'(VCO_CAL_CYCLES - 1)) begin
				bandRes_reg <= vcoBandMeas;
				amplRes_reg <= vcoAmplMeas;
				vcoDone_reg <= 1'b1;
			end else if (cmdTrx) begin
				vcoDone_reg <= 1'b0;
			end
			if (state_reg == RCC_ON_CAL &&
					cnt_reg == 16'(IFCAL_CYCLES - 1))
				ifDone_reg <= 1'b1;
			else if (cmdOn && state_reg == RCC_IDLE)
				ifDone_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Amplifier ramp
	// ----------------------------------------
	// Bit-rate tick from a phase accumulator on the data rate
	assign accSum  = {11'h000, rateDev_reg[3:0], rateLo_reg} +
		{1'b0, acc_reg};
	assign bitTick = accSum >= 23'(`RCC_BIT_ACC_MOD);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			acc_reg <= 22'h000000;
		else
			acc_reg <= bitTick ? 22'(accSum - 23'(`RCC_BIT_ACC_MOD))
				: accSum[21:0];
	end

	// Move toward target by 2^ramp codes per bit period
	// Step is eight bits wide so the fastest rate, 128 codes, keeps its bit
	assign target   = state_reg == RCC_TX ? fine_reg : 6'h00;
	assign rampStep = 8'h01 << ampCfg_reg[`RCC_RAMP_F];
	assign levelUp  = {2'b00, level_reg} + rampStep;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			level_reg <= 6'h00;
		end else if (bitTick) begin
			if (level_reg < target)
				level_reg <= levelUp > {2'b00, target} ? target
					: levelUp[5:0];
			else if ({2'b00, level_reg} > {2'b00, target} + rampStep)
				level_reg <= level_reg - rampStep[5:0];
			else
				level_reg <= target;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign paCtl.level    = level_reg;
	assign paCtl.singleEn = level_reg != 6'h00 &&
		!ampCfg_reg[`RCC_PA_SEL_BIT];
	assign paCtl.diffEn   = level_reg != 6'h00 &&
		ampCfg_reg[`RCC_PA_SEL_BIT];
	assign modemCfg.modFormat = rcc_mod_t'(modCfg_reg[`RCC_MOD_F]);
	assign modemCfg.gaussian  = modCfg_reg[`RCC_MOD_F] == RCC_GFSK ||
		modCfg_reg[`RCC_MOD_F] == RCC_GMSK;
	assign modemCfg.btX10     = `RCC_GAUSS_BT_X10;
	assign modemCfg.ifBandwidthSelect = modCfg_reg[`RCC_IF_BANDWIDTH_SELECT_F];
	assign modemCfg.if300k    = modCfg_reg[`RCC_IF_BANDWIDTH_SELECT_F] ==
		`RCC_IF_BANDWIDTH_SELECT_300;
	assign modemCfg.deviationValue = {rateDev_reg[7:4], devLo_reg};
	assign modemCfg.dataRate  = {rateDev_reg[3:0], rateLo_reg};
	assign vcoCtl.useOverride = ovrEn_reg == `RCC_OVR_ALL;
	assign vcoCtl.band   = vcoCtl.useOverride ? bandOvr_reg
		: bandRes_reg;
	assign vcoCtl.ampl   = vcoCtl.useOverride ? amplOvr_reg
		: amplRes_reg;
	assign vcoCtl.calRun = state_reg == RCC_VCO_CAL;
	assign xtalPullSteps = `RCC_TRIM_ZERO -
		{1'b0, oscSetup_reg[`RCC_TRIM_F]};
	assign ifCalRun      = state_reg == RCC_ON_CAL;
	assign radioState    = state_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_bypass;
		state_reg == RCC_ON && cmdTrx && bypass |=>
			state_reg == RCC_SETTLE ##1 state_reg != RCC_VCO_CAL;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass still ran calibration");

	property p_cal_on_cmd;
		state_reg == RCC_ON && cmdTrx && !bypass |=>
			state_reg == RCC_VCO_CAL && vcoCtl.calRun;
	endproperty
	a_cal_on_cmd: assert property (p_cal_on_cmd)
		else $error("command did not start calibration");

	property p_cal_end;
		state_reg == RCC_VCO_CAL && cnt_reg == 16'(VCO_CAL_CYCLES - 1)
			&& !cmdOff |=> state_reg == RCC_SETTLE && vcoDone_reg
			&& bandRes_reg == $past(vcoBandMeas);
	endproperty
	a_cal_end: assert property (p_cal_end)
		else $error("calibration end wrong");

	property p_settle;
		$rose(state_reg == RCC_TX) |-> $past(state_reg) == RCC_SETTLE
			&& $past(cnt_reg) == 16'(SETTLE_CYCLES - 1);
	endproperty
	a_settle: assert property (p_settle)
		else $error("transmit entered before settling");

	property p_pa_excl;
		!(paCtl.singleEn && paCtl.diffEn);
	endproperty
	a_pa_excl: assert property (p_pa_excl)
		else $error("both amplifiers enabled");

	property p_fine;
		wrEn && idx == `RCC_IDX_AMP_CFG |=> fine_reg ==
			(6'($past(pwdata[`RCC_COARSE_F])) << 2) + 6'h03;
	endproperty
	a_fine: assert property (p_fine)
		else $error("fine level not four times coarse plus three");

	property p_ramp;
		$changed(level_reg) |-> $past(bitTick);
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("level moved off bit tick");

	property p_ifcal;
		state_reg == RCC_IDLE && cmdOn && options_reg[`RCC_BBCAL_BIT]
			|=> ifCalRun;
	endproperty
	a_ifcal: assert property (p_ifcal)
		else $error("IF calibration not started");

	property p_override;
		ovrEn_reg == `RCC_OVR_ALL |-> vcoCtl.band == bandOvr_reg &&
			vcoCtl.ampl == amplOvr_reg;
	endproperty
	a_override: assert property (p_override)
		else $error("override not applied");

	c_bypass: cover property (state_reg == RCC_ON && cmdTx && bypass);
	c_cal: cover property (state_reg == RCC_VCO_CAL ##1
		state_reg == RCC_SETTLE);
	c_ifcal: cover property ($fell(ifCalRun));
	c_diff: cover property (paCtl.diffEn);
endmodule

// file: design/rcc_regs.svh
/*
 * Register indices, field positions, codes and timing for the radio
 * calibration and configuration bank.
 * Assumes: byte address on the bus is four times the register index.
 */
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define RCC_IDX_RATE_LO     10'h10C
`define RCC_IDX_RATE_DEV    10'h10D
`define RCC_IDX_DEV_LO      10'h10E
`define RCC_IDX_AMP_CFG     10'h114
`define RCC_IDX_MOD_CFG     10'h115
`define RCC_IDX_IMG_PHASE   10'h118
`define RCC_IDX_IMG_AMPL    10'h119
`define RCC_IDX_OPTIONS     10'h11A
`define RCC_IDX_FINE_PWR    10'h307
`define RCC_IDX_SYNTH_CTRL  10'h338
`define RCC_IDX_CAL_STATUS  10'h339
`define RCC_IDX_BAND_OVR    10'h3CB
`define RCC_IDX_AMPL_OVR    10'h3CC
`define RCC_IDX_OVR_EN      10'h3CD
`define RCC_IDX_VCO_SETUP   10'h3D0
`define RCC_IDX_OSC_SETUP   10'h3D2
`define RCC_IDX_BAND_RES    10'h3DA
`define RCC_IDX_AMPL_RES    10'h3DB
`define RCC_IDX_COMMAND     10'h3E0
// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define RCC_OVR_ALL         8'h03
`define RCC_VCO_BYPASS      8'h0F
`define RCC_SYNTH_CAL_BIT   0
`define RCC_BBCAL_BIT       0
`define RCC_TRIM_F          2:0
`define RCC_TRIM_ZERO       4'h4
`define RCC_PA_SEL_BIT      0
`define RCC_COARSE_F        4:1
`define RCC_RAMP_F          7:5
`define RCC_FINE_F          5:0
`define RCC_FINE_SHIFT      2
`define RCC_FINE_OFS        6'h03
`define RCC_MOD_F           5:4
`define RCC_IF_BANDWIDTH_SELECT_F          7:6
`define RCC_IF_BANDWIDTH_SELECT_300        2'h3
`define RCC_GAUSS_BT_X10    4'h5
`define RCC_CMD_OFF         8'h00
`define RCC_CMD_ON          8'h01
`define RCC_CMD_TX          8'h02
`define RCC_CMD_RX          8'h03
// ----------------------------------------
// Timing
// ----------------------------------------
`define RCC_CLK_MHZ         250
`define RCC_VCO_CAL_US      142
`define RCC_SETTLE_US       56
`define RCC_IFCAL_US        100
`define RCC_RATE_UNIT_BPS   100
`define RCC_BIT_ACC_MOD     ((`RCC_CLK_MHZ * 1000000) / `RCC_RATE_UNIT_BPS)
`endif

// file: sim/rcc_radio_calib_config_test.sv
/*
 * Self-checking bench for the radio calibration and configuration bank.
 * Assumes: the design package and register header, short timing counts.
 */
`timescale 1ns/1ps
`include "rcc_regs.svh"
`define CHECK(nm, ex, got) begin \
	checkCount++; \
	if ((got) !== (ex)) begin \
		failCount++; \
		$display("ERROR %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module rcc_radio_calib_config_test;
	import rcc_pkg::*;
	localparam int VCO_N = 20;
	localparam int SET_N = 10;
	localparam int IF_N  = 15;
	logic              core_clk;
	logic              nrst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [7:0]        vcoBandMeas;
	logic [7:0]        vcoAmplMeas;
	rcc_modem_t        modemCfg;
	rcc_pa_t           paCtl;
	rcc_vco_t          vcoCtl;
	logic signed [3:0] xtalPullSteps;
	logic              ifCalRun;
	rcc_state_t        radioState;
	int                failCount;
	int                checkCount;
	int                n;
	logic [7:0]        rdat;
	logic              rerr;
	rcc_radio_calib_config #(
		.VCO_CAL_CYCLES(VCO_N),
		.SETTLE_CYCLES (SET_N),
		.IFCAL_CYCLES  (IF_N)
	) rcc_radio_calib_config_inst (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.vcoBandMeas  (vcoBandMeas),
		.vcoAmplMeas  (vcoAmplMeas),
		.modemCfg     (modemCfg),
		.paCtl        (paCtl),
		.vcoCtl       (vcoCtl),
		.xtalPullSteps(xtalPullSteps),
		.ifCalRun     (ifCalRun),
		.radioState   (radioState)
	);
	// ----------------------------------------
	// Clock, verdict and watchdog
	// ----------------------------------------
	// Free running core clock
	always #2 core_clk = ~core_clk;
	task automatic finishTest;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Cuts a hang short after far more than the tests need
	initial begin
		#100000;
		failCount++;
		$display("ERROR watchdog expired");
		finishTest;
	end
	// ----------------------------------------
	// Bus and sequencer helpers
	// ----------------------------------------
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [7:0] wd);
		int w;
		w = 0;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			w++;
		end while (pready !== 1'b1 && w < 100);
		if (w >= 100) failCount++;
		rdat = prdata[7:0];
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
		`CHECK("wrErr", 1'b0, rerr)
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] ex);
		apb(1'b0, idx, 8'h00);
		`CHECK("rdErr", 1'b0, rerr)
		`CHECK("rdata", ex, rdat)
	endtask
	// Command write, then look half a cycle after the edge that takes it
	task automatic cmd(input logic [7:0] c);
		wr(`RCC_IDX_COMMAND, c);
		@(negedge core_clk);
	endtask
	// Counts cycles spent in one state, bounded
	task automatic stay(input rcc_state_t st);
		n = 0;
		while (radioState === st && n < 5000) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	// Waits for the amplifier level, never both amplifiers on
	task automatic ramp(input logic [5:0] lv);
		n = 0;
		while (paCtl.level !== lv && n < 5000) begin
			@(negedge core_clk);
			n++;
			`CHECK("bothAmps", 1'b0, paCtl.singleEn & paCtl.diffEn)
		end
		`CHECK("level", lv, paCtl.level)
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tAccess;
		@(negedge core_clk);
		`CHECK("state", RCC_IDLE, radioState)
		`CHECK("pull", 4'h4, xtalPullSteps)
		`CHECK("paCtl", 8'h00, paCtl)
		rd(`RCC_IDX_RATE_LO, 8'h00);
		wr(`RCC_IDX_RATE_LO, 8'hAB);
		rd(`RCC_IDX_RATE_LO, 8'hAB);
		apb(1'b0, 10'h000, 8'h00);
		`CHECK("unmapErr", 1'b1, rerr)
		`CHECK("unmapData", 8'h00, rdat)
		apb(1'b1, `RCC_IDX_BAND_RES, 8'hFF);
		`CHECK("roErr", 1'b1, rerr)
		rd(`RCC_IDX_BAND_RES, 8'h00);
		wr(`RCC_IDX_IMG_AMPL, 8'h07);
		wr(`RCC_IDX_IMG_PHASE, 8'h16);
		rd(`RCC_IDX_IMG_AMPL, 8'h07);
		rd(`RCC_IDX_IMG_PHASE, 8'h16);
	endtask
	task automatic tModem;
		logic [1:0] mm;
		logic [1:0] bb;
		wr(`RCC_IDX_RATE_DEV, 8'h5C);
		wr(`RCC_IDX_DEV_LO, 8'h12);
		@(negedge core_clk);
		`CHECK("rate", 12'hCAB, modemCfg.dataRate)
		`CHECK("dev", 12'h512, modemCfg.deviationValue)
		for (int i = 0; i < 16; i++) begin
			mm = i[1:0];
			bb = i[3:2];
			wr(`RCC_IDX_MOD_CFG, {bb, mm, 4'h0});
			@(negedge core_clk);
			`CHECK("mod", mm, modemCfg.modFormat)
			`CHECK("gauss", mm[1], modemCfg.gaussian)
			`CHECK("bt", 4'h5, modemCfg.btX10)
			`CHECK("if_bandwidth_select", bb, modemCfg.ifBandwidthSelect)
			`CHECK("if300", bb == 2'h3, modemCfg.if300k)
		end
	endtask
	task automatic tTrim;
		for (int i = 0; i < 8; i++) begin
			wr(`RCC_IDX_OSC_SETUP, i[7:0]);
			@(negedge core_clk);
			`CHECK("pull", 4'(4 - i), xtalPullSteps)
		end
	endtask
	task automatic tAmplifier;
		wr(`RCC_IDX_AMP_CFG, 8'hEB);
		rd(`RCC_IDX_FINE_PWR, 8'h17);
		wr(`RCC_IDX_FINE_PWR, 8'h3F);
		rd(`RCC_IDX_FINE_PWR, 8'h3F);
	endtask
	task automatic tIfCal;
		cmd(`RCC_CMD_TX);
		`CHECK("refused", RCC_IDLE, radioState)
		wr(`RCC_IDX_OPTIONS, 8'h01);
		cmd(`RCC_CMD_ON);
		`CHECK("state", RCC_ON_CAL, radioState)
		`CHECK("ifCal", 1'b1, ifCalRun)
		stay(RCC_ON_CAL);
		`CHECK("ifCycles", IF_N, n)
		`CHECK("state", RCC_ON, radioState)
		`CHECK("ifCal", 1'b0, ifCalRun)
	endtask
	task automatic tCalibrate;
		cmd(`RCC_CMD_TX);
		`CHECK("state", RCC_VCO_CAL, radioState)
		`CHECK("calRun", 1'b1, vcoCtl.calRun)
		stay(RCC_VCO_CAL);
		`CHECK("calCycles", VCO_N, n)
		`CHECK("state", RCC_SETTLE, radioState)
		stay(RCC_SETTLE);
		`CHECK("setCycles", SET_N, n)
		`CHECK("state", RCC_TX, radioState)
		rd(`RCC_IDX_BAND_RES, 8'h5A);
		rd(`RCC_IDX_AMPL_RES, 8'hA5);
		apb(1'b0, `RCC_IDX_CAL_STATUS, 8'h00);
		`CHECK("calDone", 1'b1, rdat[0])
		`CHECK("ifDone", 1'b1, rdat[1])
		`CHECK("band", 8'h5A, vcoCtl.band)
		ramp(6'h3F);
		`CHECK("diff", 1'b1, paCtl.diffEn)
		wr(`RCC_IDX_AMP_CFG, 8'hCA);
		ramp(6'h17);
		`CHECK("single", 1'b1, paCtl.singleEn)
		`CHECK("diff", 1'b0, paCtl.diffEn)
		cmd(`RCC_CMD_OFF);
		ramp(6'h00);
		`CHECK("single", 1'b0, paCtl.singleEn)
	endtask
	task automatic tBypass;
		wr(`RCC_IDX_OPTIONS, 8'h00);
		cmd(`RCC_CMD_ON);
		`CHECK("state", RCC_ON, radioState)
		wr(`RCC_IDX_OVR_EN, `RCC_OVR_ALL);
		wr(`RCC_IDX_VCO_SETUP, `RCC_VCO_BYPASS);
		wr(`RCC_IDX_BAND_OVR, 8'h33);
		wr(`RCC_IDX_AMPL_OVR, 8'h44);
		wr(`RCC_IDX_SYNTH_CTRL, 8'h00);
		wr(`RCC_IDX_SYNTH_CTRL, 8'h01);
		@(negedge core_clk);
		`CHECK("useOvr", 1'b1, vcoCtl.useOverride)
		`CHECK("band", 8'h33, vcoCtl.band)
		`CHECK("ampl", 8'h44, vcoCtl.ampl)
		cmd(`RCC_CMD_RX);
		`CHECK("state", RCC_SETTLE, radioState)
		`CHECK("calRun", 1'b0, vcoCtl.calRun)
		stay(RCC_SETTLE);
		`CHECK("setCycles", SET_N, n)
		`CHECK("state", RCC_RX, radioState)
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Reset for five cycles, then every scenario in turn
	initial begin
		core_clk    = 1'b0;
		nrst        = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 12'h000;
		pwdata      = 32'h0;
		vcoBandMeas = 8'h5A;
		vcoAmplMeas = 8'hA5;
		failCount   = 0;
		checkCount  = 0;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		tAccess;
		tModem;
		tTrim;
		tAmplifier;
		tIfCal;
		tCalibrate;
		tBypass;
		finishTest;
	end
endmodule
